// ==== rtl/sisp_pkg.sv ====
// -----------------------------------------------------------------------------
// Shared constants of the serial programming port.
// -----------------------------------------------------------------------------
package sisp_pkg;

  // System clock rate and the width of every wait counter.
  localparam int CLK_HZ = 20_000_000;
  localparam int CNT_W  = 20;

  // Waits in their own units and in system clock cycles.
  localparam int PWRUP_WAIT_MS    = 20;
  localparam int PWRUP_WAIT_CYC   = PWRUP_WAIT_MS * (CLK_HZ / 1000);
  localparam int PROG_WAIT_US     = 4000;
  localparam int PROG_WAIT_CYC    = PROG_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_WAIT_US    = 9000;
  localparam int ERASE_WAIT_CYC   = ERASE_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int SCK_HALF_CYC     = 8;
  localparam int RST_PULSE_CYC    = 8;
  localparam int MAX_TRIES        = 32;

  // Memory geometry: flash as bytes of 16-bit words, eeprom as bytes.
  localparam int FL_BYTES  = 2048;
  localparam int EE_BYTES  = 128;
  localparam int FL_HI_BIT = 3;

  // Instruction bytes and poll values.
  localparam logic [7:0] OP_PEN1        = 8'hac;
  localparam logic [7:0] OP_PEN2        = 8'h53;
  localparam logic [7:0] OP_ERASE2      = 8'h80;
  localparam logic [7:0] OP_RD_FL       = 8'h20;
  localparam logic [7:0] OP_WR_FL       = 8'h40;
  localparam logic [7:0] OP_RD_EE       = 8'ha0;
  localparam logic [7:0] OP_WR_EE       = 8'hc0;
  localparam logic [7:0] FL_OP_MASK     = 8'hf7;
  localparam logic [7:0] POLL_ERASING   = 8'h00;
  localparam logic [7:0] POLL_ERASED    = 8'hff;

  // Operations that the programmer's user side may request.
  typedef enum logic [2:0] {
    OP_CONNECT = 3'b000,
    OP_XFER    = 3'b001,
    OP_WRITE   = 3'b010,
    OP_ERASE   = 3'b011,
    OP_RELEASE = 3'b100
  } sisp_op_t;

endpackage

// ==== rtl/sisp_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Pins between the programmer and the target.
// -----------------------------------------------------------------------------
interface sisp_link_if;
  logic sck;
  logic serial_in_port_pin;
  logic serial_out_port_pin;
  logic rst_n;
  logic clock_input_run;

  // Programmer end and target end.
  modport prog (output sck, output serial_in_port_pin, output rst_n,
                output clock_input_run, input serial_out_port_pin);
  modport dev  (input sck, input serial_in_port_pin, input rst_n,
                input clock_input_run, output serial_out_port_pin);
endinterface
`default_nettype wire

// ==== rtl/sisp_target.sv ====
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Target end: serial instruction decoder with flash and eeprom arrays.
// -----------------------------------------------------------------------------
module sisp_target
#(
  parameter int PROG_CYC  = sisp_pkg::PROG_WAIT_CYC,
  parameter int ERASE_CYC = sisp_pkg::ERASE_WAIT_CYC
)
(
  // Clock and reset.
  input  wire logic  i_clk,
  input  wire logic  i_resetn,
  // Link to the programmer.
  sisp_link_if.dev   link,
  // Status.
  output logic       o_prog_mode,
  output logic       o_busy
);
  import sisp_pkg::*;

  typedef enum logic [2:0] {
    W_IDLE = 3'b000,
    W_FL   = 3'b001,
    W_EEER = 3'b010,
    W_EEWR = 3'b011,
    W_CE   = 3'b100
  } sisp_wst_t;

  logic [7:0]       fl_mem [0:FL_BYTES-1];
  logic [7:0]       ee_mem [0:EE_BYTES-1];
  logic             sck_s1, sck_s2, sck_d, din_s1, din_s2, rstn_s1, rstn_s2;
  logic [7:0]       rx_ff, out_ff, b1_ff, b2_ff, b3_ff, wd_ff;
  logic [15:0]      hunt_ff;
  logic [2:0]       bit_ff;
  logic [1:0]       byte_ff;
  logic             algn_ff, en_ff, dout_ff, prog_ff, busy_ff;
  sisp_wst_t        st_ff;
  logic [CNT_W-1:0] wt_ff;
  logic [10:0]      wa_ff;

  // Pin inputs pass two flip-flops before any logic reads them.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {sck_s1, sck_s2, sck_d, din_s1, din_s2} <= 5'h00;
      {rstn_s1, rstn_s2} <= 2'h3;
    end
    else
    begin
      {sck_s1, sck_s2, sck_d} <= {link.sck, sck_s1, sck_s2};
      {din_s1, din_s2} <= {link.serial_in_port_pin, din_s1};
      {rstn_s1, rstn_s2} <= {link.rst_n, rstn_s1};
    end
  end

  // Edge detection, bit shifting and decode of the current instruction.
  wire        active   = ~rstn_s2;
  wire        rise     = sck_s2 & ~sck_d;
  wire        fall     = ~sck_s2 & sck_d;
  wire [7:0]  rx_nxt   = {rx_ff[6:0], din_s2};
  wire [15:0] hunt_nxt = {hunt_ff[14:0], din_s2};
  wire        hunt_hit = rise & ~algn_ff & (hunt_nxt == {OP_PEN1, OP_PEN2});
  wire        byte_end = rise & algn_ff & (bit_ff == 3'h7);
  wire        is_rd_fl = (b1_ff & FL_OP_MASK) == OP_RD_FL;
  wire        is_rd_ee = b1_ff == OP_RD_EE;
  wire        is_wr_fl = (b1_ff & FL_OP_MASK) == OP_WR_FL;
  wire        is_wr_ee = b1_ff == OP_WR_EE;
  wire        is_ce    = (b1_ff == OP_PEN1) & (b2_ff == OP_ERASE2);
  wire [10:0] fl_ra    = {b2_ff[1:0], rx_nxt, b1_ff[FL_HI_BIT]};
  wire [6:0]  ee_ra    = rx_nxt[6:0];

  // Read data, with poll values while the addressed byte is being written.
  wire        fl_poll  = (st_ff == W_FL) & (wa_ff == fl_ra);
  wire        ee_poll  = (st_ff == W_EEER) & (wa_ff[6:0] == ee_ra);
  wire [7:0]  fl_val   = fl_poll ? POLL_ERASED : fl_mem[fl_ra];
  wire [7:0]  ee_val   = ee_poll ? POLL_ERASING : ee_mem[ee_ra];
  wire        rd_slot  = (byte_ff == 2'h2) & (is_rd_fl | is_rd_ee);
  wire [7:0]  rd_val   = is_rd_ee ? ee_val : fl_val;
  wire [7:0]  out_nxt  = rd_slot ? rd_val : rx_nxt;

  // Frame tracking: hunt for the enable pattern, then count bytes.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {rx_ff, out_ff, b1_ff, b2_ff, b3_ff} <= 40'h00_0000_0000;
      hunt_ff <= 16'h0000;
      {bit_ff, byte_ff, algn_ff, en_ff, dout_ff} <= 8'h00;
    end
    else if (!active)
    begin
      {hunt_ff, out_ff} <= 24'h00_0000;
      {bit_ff, byte_ff, algn_ff, en_ff, dout_ff} <= 8'h00;
    end
    else
    begin
      if (rise)
      begin
        rx_ff   <= rx_nxt;
        hunt_ff <= hunt_nxt;
        bit_ff  <= bit_ff + 3'h1;
      end
      if (hunt_hit)
      begin
        {algn_ff, bit_ff, byte_ff} <= 6'h22;
        {b1_ff, b2_ff} <= {OP_PEN1, OP_PEN2};
        out_ff <= OP_PEN2;
      end
      else if (byte_end)
      begin
        byte_ff <= byte_ff + 2'h1;
        out_ff  <= out_nxt;
        if (byte_ff == 2'h0) b1_ff <= rx_nxt;
        if (byte_ff == 2'h1) b2_ff <= rx_nxt;
        if (byte_ff == 2'h2) b3_ff <= rx_nxt;
        if (byte_ff == 2'h3) en_ff <= 1'b1;
      end
      else if (fall)
      begin
        dout_ff <= out_ff[7];
        out_ff  <= {out_ff[6:0], 1'b0};
      end
    end
  end

  // Self-timed write engine and chip erase sweep.
  wire exec     = byte_end & (byte_ff == 2'h3) & en_ff & (st_ff == W_IDLE);
  wire pg_end   = wt_ff == CNT_W'(PROG_CYC - 1);
  wire pg_half  = wt_ff == CNT_W'(PROG_CYC / 2 - 1);
  wire ce_end   = wt_ff == CNT_W'(ERASE_CYC - 1);
  wire sweep    = (st_ff == W_CE) & (wt_ff < CNT_W'(FL_BYTES));

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_ff <= W_IDLE;
      wt_ff <= '0;
      wa_ff <= 11'h000;
      wd_ff <= 8'h00;
    end
    else if (exec)
    begin
      wt_ff <= '0;
      wd_ff <= rx_nxt;
      if (is_ce) st_ff <= W_CE;
      if (is_wr_fl)
      begin
        st_ff <= W_FL;
        wa_ff <= {b2_ff[1:0], b3_ff, b1_ff[FL_HI_BIT]};
      end
      if (is_wr_ee)
      begin
        st_ff <= W_EEER;
        wa_ff <= {4'h0, b3_ff[6:0]};
      end
    end
    else if (st_ff != W_IDLE)
    begin
      wt_ff <= wt_ff + CNT_W'(1);
      if (st_ff == W_EEER && pg_half) st_ff <= W_EEWR;
      if ((st_ff == W_FL || st_ff == W_EEWR) && pg_end) st_ff <= W_IDLE;
      if (st_ff == W_CE && ce_end) st_ff <= W_IDLE;
    end
  end

  // Array write ports.
  wire        fl_we = sweep | ((st_ff == W_FL) & pg_end);
  wire [10:0] fl_wa = sweep ? wt_ff[10:0] : wa_ff;
  wire [7:0]  fl_wd = sweep ? POLL_ERASED : wd_ff;
  wire        ee_er = (st_ff == W_EEER) & pg_half;
  wire        ee_we = sweep | ee_er | ((st_ff == W_EEWR) & pg_end);
  wire [6:0]  ee_wa = sweep ? wt_ff[6:0] : wa_ff[6:0];
  wire [7:0]  ee_wd = (sweep | ee_er) ? POLL_ERASED : wd_ff;

  always_ff @(posedge i_clk)
  begin
    if (fl_we) fl_mem[fl_wa] <= fl_wd;
    if (ee_we) ee_mem[ee_wa] <= ee_wd;
  end

  // Registered status outputs.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      {prog_ff, busy_ff} <= 2'h0;
    else
      {prog_ff, busy_ff} <= {en_ff, st_ff != W_IDLE};
  end

  assign link.serial_out_port_pin = dout_ff;
  assign o_prog_mode = prog_ff;
  assign o_busy      = busy_ff;
endmodule
`default_nettype wire

// ==== rtl/sisp_programmer.sv ====
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Programmer end: drives the serial link on behalf of a user-side requester.
// -----------------------------------------------------------------------------
// Contract
// - Serial clock phases each exceed two target cycles.
// - Target samples input bits on rising clock.
// - Target changes output on falling clock.
// - Reset and serial clock held low at power-up.
// - Programmer supplies target clock when externally clocked.
// - Wait 20 ms before programming enable.
// - Target echoes second enable byte during third.
// - Always shift all four instruction bytes.
// - No echo: pulse clock, retry, 32 attempts.
// - After erase: wait, pulse reset, re-enable.
// - One byte per write, address and data.
// - Eeprom write erases the location first.
// - Without polling, wait program time after writes.
// - Read returns stored byte on output pin.
// - Reset high ends the session.
// - Power-off: clock input low, then reset high.
// - Eeprom poll reads 00, then FF, then value.
// - Eeprom 00 or FF needs full wait.
// - Flash poll reads FF until written.
// - Flash FF needs full program wait.
// - FF bytes may be skipped after erase.
// - Chip erase sets both arrays to FF.
// - Flash and eeprom have separate address ranges.
module sisp_programmer
#(
  parameter int PWRUP_CYC = sisp_pkg::PWRUP_WAIT_CYC,
  parameter int PROG_CYC  = sisp_pkg::PROG_WAIT_CYC,
  parameter int ERASE_CYC = sisp_pkg::ERASE_WAIT_CYC
)
(
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  // User-side request.
  input  wire logic             i_start,
  input  wire sisp_pkg::sisp_op_t i_op,
  input  wire logic [31:0]      i_cmd,
  // User-side answer.
  output logic                  o_ready,
  output logic                  o_done,
  output logic                  o_fail,
  output logic [7:0]            o_rdata,
  // Link to the target.
  sisp_link_if.prog             link
);
  import sisp_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE   = 4'b0000,
    H_PWR    = 4'b0001,
    H_EN     = 4'b0010,
    H_SHIFT  = 4'b0011,
    H_CHK    = 4'b0100,
    H_PULSE  = 4'b0101,
    H_WPROG  = 4'b0110,
    H_WERASE = 4'b0111,
    H_RSTP   = 4'b1000,
    H_REL    = 4'b1001,
    H_DONE   = 4'b1010
  } sisp_hst_t;

  sisp_hst_t        st_ff, nxt_st;
  sisp_op_t         op_ff, nxt_op;
  logic [31:0]      tx_ff, nxt_tx, rx_ff, nxt_rx;
  logic [2:0]       ph_ff, nxt_ph;
  logic [4:0]       bit_ff, nxt_bit;
  logic [CNT_W-1:0] wt_ff, nxt_wt, wt_lim;
  logic [5:0]       tries_ff, nxt_tries;
  logic             enph_ff, nxt_enph;
  logic             sck_ff, nxt_sck;
  logic             mosi_ff, nxt_mosi;
  logic             rstn_ff, nxt_rstn;
  logic             run_ff, nxt_run;
  logic             ready_ff, nxt_ready;
  logic             done_ff, nxt_done;
  logic             fail_ff, nxt_fail;
  logic [7:0]       rdata_ff, nxt_rdata;
  logic             miso_s1, miso_s2;

  // Returned data passes two flip-flops before it is read.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      {miso_s1, miso_s2} <= 2'h0;
    else
      {miso_s1, miso_s2} <= {link.serial_out_port_pin, miso_s1};
  end

  // Wait limit per waiting state and phase timing of the serial clock.
  always_comb
  begin
    case (st_ff)
      H_PWR:    wt_lim = CNT_W'(PWRUP_CYC - 1);
      H_WPROG:  wt_lim = CNT_W'(PROG_CYC - 1);
      H_WERASE: wt_lim = CNT_W'(ERASE_CYC - 1);
      default:  wt_lim = CNT_W'(RST_PULSE_CYC - 1);
    endcase
  end

  wire wt_hit   = wt_ff == wt_lim;
  wire ph_hit   = ph_ff == 3'(SCK_HALF_CYC - 1);
  wire echo_ok  = rx_ff[15:8] == OP_PEN2;
  wire last_try = tries_ff == 6'(MAX_TRIES);

  // Next-state logic of the sequencer.
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_op    = op_ff;
    nxt_tx    = tx_ff;
    nxt_rx    = rx_ff;
    nxt_ph    = ph_ff;
    nxt_bit   = bit_ff;
    nxt_wt    = wt_ff;
    nxt_tries = tries_ff;
    nxt_enph  = enph_ff;
    nxt_sck   = sck_ff;
    nxt_mosi  = mosi_ff;
    nxt_rstn  = rstn_ff;
    nxt_run   = run_ff;
    nxt_ready = ready_ff;
    nxt_done  = 1'b0;
    nxt_fail  = fail_ff;
    nxt_rdata = rdata_ff;
    case (st_ff)
      H_IDLE:
      begin
        nxt_ready = 1'b1;
        if (i_start)
        begin
          nxt_ready = 1'b0;
          nxt_op    = i_op;
          nxt_wt    = '0;
          nxt_ph    = 3'h0;
          nxt_bit   = 5'h00;
          if (i_op == OP_CONNECT)
          begin
            nxt_rstn  = 1'b0;
            nxt_sck   = 1'b0;
            nxt_run   = 1'b1;
            nxt_tries = 6'h00;
            nxt_fail  = 1'b0;
            nxt_st    = H_PWR;
          end
          else if (i_op == OP_RELEASE)
          begin
            nxt_run = 1'b0;
            nxt_st  = H_REL;
          end
          else
          begin
            nxt_tx   = i_cmd;
            nxt_mosi = i_cmd[31];
            nxt_st   = H_SHIFT;
          end
        end
      end
      H_PWR:
      begin
        nxt_wt = wt_ff + CNT_W'(1);
        if (wt_hit)
        begin
          nxt_wt = '0;
          nxt_st = H_EN;
        end
      end
      H_EN:
      begin
        nxt_tx    = {OP_PEN1, OP_PEN2, 16'h0000};
        nxt_mosi  = OP_PEN1[7];
        nxt_tries = tries_ff + 6'h01;
        nxt_enph  = 1'b1;
        nxt_ph    = 3'h0;
        nxt_bit   = 5'h00;
        nxt_st    = H_SHIFT;
      end
      H_SHIFT:
      begin
        nxt_ph = ph_ff + 3'h1;
        if (ph_hit && !sck_ff)
        begin
          nxt_ph  = 3'h0;
          nxt_sck = 1'b1;
          nxt_rx  = {rx_ff[30:0], miso_s2};
        end
        else if (ph_hit)
        begin
          nxt_ph   = 3'h0;
          nxt_sck  = 1'b0;
          nxt_tx   = {tx_ff[30:0], 1'b0};
          nxt_mosi = tx_ff[30];
          nxt_bit  = bit_ff + 5'h01;
          if (bit_ff == 5'h1f)
          begin
            if (enph_ff)
              nxt_st = H_CHK;
            else if (op_ff == OP_WRITE)
              nxt_st = H_WPROG;
            else if (op_ff == OP_ERASE)
              nxt_st = H_WERASE;
            else
              nxt_st = H_DONE;
          end
        end
      end
      H_CHK:
      begin
        nxt_enph = 1'b0;
        if (echo_ok)
          nxt_st = H_DONE;
        else if (last_try)
        begin
          nxt_fail = 1'b1;
          nxt_st   = H_DONE;
        end
        else
          nxt_st = H_PULSE;
      end
      H_PULSE:
      begin
        nxt_ph = ph_ff + 3'h1;
        if (ph_hit && !sck_ff)
        begin
          nxt_ph  = 3'h0;
          nxt_sck = 1'b1;
        end
        else if (ph_hit)
        begin
          nxt_ph  = 3'h0;
          nxt_sck = 1'b0;
          nxt_st  = H_EN;
        end
      end
      H_WPROG:
      begin
        nxt_wt = wt_ff + CNT_W'(1);
        if (wt_hit)
        begin
          nxt_wt = '0;
          nxt_st = H_DONE;
        end
      end
      H_WERASE:
      begin
        nxt_wt = wt_ff + CNT_W'(1);
        if (wt_hit)
        begin
          nxt_wt   = '0;
          nxt_rstn = 1'b1;
          nxt_st   = H_RSTP;
        end
      end
      H_RSTP:
      begin
        nxt_wt = wt_ff + CNT_W'(1);
        if (wt_hit)
        begin
          nxt_wt   = '0;
          nxt_rstn = 1'b0;
          nxt_st   = H_PWR;
        end
      end
      H_REL:
      begin
        nxt_rstn = 1'b1;
        nxt_st   = H_DONE;
      end
      H_DONE:
      begin
        nxt_done  = 1'b1;
        nxt_rdata = rx_ff[7:0];
        nxt_st    = H_IDLE;
      end
      default:
        nxt_st = H_IDLE;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_ff    <= H_IDLE;
      op_ff    <= OP_CONNECT;
      {tx_ff, rx_ff} <= 64'h0000_0000_0000_0000;
      {ph_ff, bit_ff, tries_ff} <= 14'h0000;
      wt_ff    <= '0;
      {enph_ff, sck_ff, mosi_ff, rstn_ff, run_ff} <= 5'h00;
      {ready_ff, done_ff, fail_ff} <= 3'h0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      st_ff    <= nxt_st;
      op_ff    <= nxt_op;
      {tx_ff, rx_ff} <= {nxt_tx, nxt_rx};
      {ph_ff, bit_ff, tries_ff} <= {nxt_ph, nxt_bit, nxt_tries};
      wt_ff    <= nxt_wt;
      {enph_ff, sck_ff, mosi_ff, rstn_ff, run_ff} <=
        {nxt_enph, nxt_sck, nxt_mosi, nxt_rstn, nxt_run};
      {ready_ff, done_ff, fail_ff} <= {nxt_ready, nxt_done, nxt_fail};
      rdata_ff <= nxt_rdata;
    end
  end

  // Pins and user outputs come straight from flip-flops.
  assign link.sck                = sck_ff;
  assign link.serial_in_port_pin = mosi_ff;
  assign link.rst_n              = rstn_ff;
  assign link.clock_input_run    = run_ff;
  assign o_ready = ready_ff;
  assign o_done  = done_ff;
  assign o_fail  = fail_ff;
  assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

// ==== tb/sisp_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// Link checker for the serial programming port.
// ------------------------------------------------
module sisp_monitor
#(
  parameter int PWRUP_CYC = 50
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Link pins.
  input wire logic sck,
  input wire logic serial_in_port_pin,
  input wire logic serial_out_port_pin,
  input wire logic rst_n,
  input wire logic clock_input_run
);
  import sisp_pkg::*;
  default clocking mon_cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // Clock history, reset-low age, age since the last fall and bit histories.
  logic        sck_ff;
  logic [15:0] low_ff;
  logic [3:0]  fall_ff;
  logic [22:0] mosi_ff;
  logic [6:0]  miso_ff;
  wire         rise_w   = sck & ~sck_ff;
  wire  [15:0] nxt_low  = rst_n ? 16'h0 : low_ff + {15'h0, ~&low_ff};
  wire  [3:0]  nxt_fall = (sck_ff & ~sck) ? 4'h0 : fall_ff + {3'h0, ~&fall_ff};

  // Ages saturate so that long idle spans do not wrap.
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      {sck_ff, low_ff, fall_ff} <= '0;
    else
      {sck_ff, low_ff, fall_ff} <= {sck, nxt_low, nxt_fall};

  // Both data lines are recorded at each rising serial clock.
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      {mosi_ff, miso_ff} <= '0;
    else if (rise_w)
      {mosi_ff, miso_ff} <= {mosi_ff[21:0], serial_in_port_pin, miso_ff[5:0], serial_out_port_pin};

  // Enable header complete at the last bit of byte three, and the echo it earns.
  sequence s_en_hdr;
    rise_w && mosi_ff[22:15] == OP_PEN1 && mosi_ff[14:7] == OP_PEN2;
  endsequence
  sequence s_echo;
    {miso_ff, serial_out_port_pin} == OP_PEN2;
  endsequence

  // ------------------------------------------------
  // Assertions.
  // ------------------------------------------------
  a_sck_low_phase : assert property ($fell(sck) |-> !sck [*3])
    else $error("serial clock low phase too short");
  a_sck_high_phase : assert property ($rose(sck) |=> sck [*2])
    else $error("serial clock high phase too short");
  a_mosi_on_low : assert property ($changed(serial_in_port_pin) |-> !sck)
    else $error("serial input moved while clock high");
  a_miso_hold_high : assert property (sck && $past(sck) |-> $stable(serial_out_port_pin))
    else $error("serial output moved while clock high");
  a_miso_after_fall : assert property ($changed(serial_out_port_pin) && low_ff > 16'h8
                                       |-> fall_ff < 4'h6)
    else $error("serial output moved away from a falling clock");
  a_enable_echo : assert property (s_en_hdr |-> s_echo)
    else $error("enable byte not echoed");
  a_enable_wait : assert property ($rose(sck) |-> low_ff >= 16'(PWRUP_CYC))
    else $error("shifting began before the power-up wait");
  a_idle_sck_low : assert property (rst_n |-> !sck)
    else $error("serial clock high outside a session");
  a_rst_pulse_len : assert property ($rose(rst_n) |-> rst_n [*3])
    else $error("target reset pulse too short");
  a_clock_supplied : assert property ($rose(sck) |-> clock_input_run)
    else $error("shifting without target clock");
endmodule
`default_nettype wire

// ==== tb/sisp_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// Bench: programmer and target joined by one link.
// ------------------------------------------------
module sisp_tb;
  import sisp_pkg::*;
  localparam int PWR = 50;
  localparam int PRG = 1600;
  localparam int ERS = 3000;

  // Design pins, reference arrays and counters.
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_start = 1'b0;
  sisp_op_t    i_op = OP_CONNECT;
  logic [31:0] i_cmd = 32'h0;
  logic        o_ready, o_done, o_fail, o_prog_mode, o_busy;
  logic [7:0]  o_rdata;
  logic [7:0]  fl_m [FL_BYTES];
  logic [7:0]  ee_m [EE_BYTES];
  logic [31:0] rd_q [$];
  int          errors = 0;
  int          n_tests = 0;
  int          seed = 32'h86a7c68c;
  sisp_link_if link ();

  // Both ends and the link checker.
  sisp_programmer #(.PWRUP_CYC(PWR), .PROG_CYC(PRG), .ERASE_CYC(ERS)) sisp_programmer_i
  (.i_clk(i_clk), .i_resetn(i_resetn), .i_start(i_start), .i_op(i_op), .i_cmd(i_cmd),
   .o_ready(o_ready), .o_done(o_done), .o_fail(o_fail), .o_rdata(o_rdata), .link(link));
  sisp_target #(.PROG_CYC(PRG), .ERASE_CYC(ERS)) sisp_target_i
  (.i_clk(i_clk), .i_resetn(i_resetn), .link(link), .o_prog_mode(o_prog_mode), .o_busy(o_busy));
  sisp_monitor #(.PWRUP_CYC(PWR)) sisp_monitor_i
  (.i_clk(i_clk), .i_resetn(i_resetn), .sck(link.sck),
   .serial_in_port_pin(link.serial_in_port_pin),
   .serial_out_port_pin(link.serial_out_port_pin), .rst_n(link.rst_n),
   .clock_input_run(link.clock_input_run));

  // The system clock toggles every half period.
  always #25 i_clk = ~i_clk;

  // Builds a read or write instruction for either array.
  function automatic logic [31:0] mk(input logic w, e, input logic [9:0] a, input logic h,
                                     input logic [7:0] d);
    if (e)
      return {w ? OP_WR_EE : OP_RD_EE, 9'h0, a[6:0], d};
    return {(w ? OP_WR_FL : OP_RD_FL) | {4'h0, h, 3'h0}, 6'h0, a, d};
  endfunction

  // Expected byte of a read instruction, taken from the reference arrays.
  function automatic logic [7:0] exp_of(input logic [31:0] c);
    return (c[31:24] == OP_RD_EE) ? ee_m[c[14:8]] : fl_m[{c[17:8], c[27]}];
  endfunction

  // Compares a byte and a flag.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // Hands one request to the programmer and waits for its completion.
  task automatic run(input sisp_op_t op, input logic [31:0] cmd);
    int k;
    k = 0;
    while (o_ready !== 1'b1 && k < 9000)
    begin
      @(negedge i_clk);
      k++;
    end
    i_op    = op;
    i_cmd   = cmd;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    k = 0;
    while (o_done !== 1'b1 && k < 9000)
    begin
      @(negedge i_clk);
      k++;
    end
    chkb(k < 9000, 1'b1);
  endtask

  // Reads one location and compares the returned byte.
  task automatic rdchk(input logic [31:0] cmd, input logic [7:0] exp);
    run(OP_XFER, cmd);
    chk(o_rdata, exp);
  endtask

  // Writes one byte, updates the reference and queues a read-back.
  task automatic put(input sisp_op_t op, input logic e, input logic [9:0] a, input logic h,
                     input logic [7:0] d);
    run(op, mk(1'b1, e, a, h, d));
    if (e)
      ee_m[a[6:0]] = d;
    else
      fl_m[{a, h}] = d;
    rd_q.push_back(mk(1'b0, e, a, h, 8'h0));
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (90000) @(posedge i_clk);
    errors++;
    $display("wrong value at %0t: run did not finish", $time);
    finish_test;
  end

  // Main sequence: connect, erase, poll, write, read back, release.
  initial
  begin
    int i;
    logic [9:0] a;
    repeat (20) @(negedge i_clk);
    i_resetn = 1'b1;
    run(OP_CONNECT, {OP_PEN1, OP_PEN2, 16'h0});
    chkb(o_fail, 1'b0);
    chkb(o_prog_mode, 1'b1);
    $display("test connect done");
    run(OP_ERASE, {OP_PEN1, OP_ERASE2, 16'h0});
    chkb(o_prog_mode, 1'b1);
    foreach (fl_m[j]) fl_m[j] = 8'hff;
    foreach (ee_m[j]) ee_m[j] = 8'hff;
    for (i = 0; i < 4; i++)
    begin
      a = (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : (i == 2) ? 10'h07f : 10'($random(seed));
      rdchk(mk(1'b0, 1'b0, a, i[0], 8'h0), 8'hff);
      rdchk(mk(1'b0, 1'b1, a, 1'b0, 8'h0), 8'hff);
    end
    $display("test erase done");
    put(OP_WRITE, 1'b1, 10'h011, 1'b0, 8'ha5);
    put(OP_XFER, 1'b1, 10'h011, 1'b0, 8'h3c);
    chkb(o_busy, 1'b1);
    rdchk(mk(1'b0, 1'b1, 10'h011, 1'b0, 8'h0), POLL_ERASING);
    rdchk(mk(1'b0, 1'b1, 10'h011, 1'b0, 8'h0), POLL_ERASED);
    repeat (PRG) @(negedge i_clk);
    rdchk(mk(1'b0, 1'b1, 10'h011, 1'b0, 8'h0), 8'h3c);
    put(OP_WRITE, 1'b0, 10'h155, 1'b1, 8'h69);
    put(OP_XFER, 1'b0, 10'h155, 1'b1, 8'h96);
    rdchk(mk(1'b0, 1'b0, 10'h155, 1'b1, 8'h0), 8'hff);
    repeat (PRG) @(negedge i_clk);
    rdchk(mk(1'b0, 1'b0, 10'h155, 1'b1, 8'h0), 8'h96);
    $display("test poll done");
    put(OP_WRITE, 1'b1, 10'h07f, 1'b0, 8'h5a);
    put(OP_WRITE, 1'b0, 10'h07f, 1'b0, 8'ha5);
    put(OP_WRITE, 1'b0, 10'h3ff, 1'b1, 8'h00);
    put(OP_WRITE, 1'b1, 10'h07f, 1'b0, 8'hc3);
    put(OP_WRITE, 1'b1, 10'h011, 1'b0, 8'hff);
    for (i = 0; i < 10; i++)
      put(OP_WRITE, 1'($random(seed)), 10'($random(seed)), 1'($random(seed)), 8'($random(seed)));
    foreach (rd_q[j]) rdchk(rd_q[j], exp_of(rd_q[j]));
    $display("test write done");
    run(OP_RELEASE, 32'h0);
    repeat (8) @(negedge i_clk);
    chkb(o_prog_mode, 1'b0);
    $display("test release done");
    finish_test;
  end
endmodule
`default_nettype wire
